// ---- hdl/wrs_supervisor.sv ----
// Watchdog, operating mode and system reset supervisor with an APB register slave.
// Assumes analog comparators deliver supply, temperature and wake levels synchronous to core_clk_i.
`default_nettype none
module wrs_supervisor
   import wrs_pkg::*;
#(
   parameter int TICK_CYC_P = TICK_CYC
)
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] supply_uv_i,
   input wire logic overtemp_i,
   input wire logic overtemp_warn_i,
   input wire logic wake_i,
   input wire logic reset_out_n_i,
   output logic reset_out_n_o,
   output logic reset_out_n_oe_o,
   output logic rxd_force_low_o,
   output logic main_supply_en_o,
   output logic xcvr_en_o,
   output logic [2:0] op_mode_o
);
   wrs_state_type st_r;
   wrs_state_type st_nxt;
   logic tick;
   logic [6:0] idx;
   logic addr_ok;
   logic access;
   logic wr_commit;
   logic [15:0] period;
   logic [15:0] half;
   logic [7:0] rst_len;
   logic [31:0] rd_val;
   logic mapped;

   wrs_tick_gen #(
      .TICK_CYC_P(TICK_CYC_P)
   ) u_tick (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .tick_o(tick)
   );

   // Nominal period in ticks; doubles as the validity check of a period code
   function automatic logic [15:0] period_ticks(input logic [3:0] sel);
      case (sel)
         NWP_8: period_ticks = 16'(8 * TICKS_PER_MS);
         NWP_16: period_ticks = 16'(16 * TICKS_PER_MS);
         NWP_32: period_ticks = 16'(32 * TICKS_PER_MS);
         NWP_64: period_ticks = 16'(64 * TICKS_PER_MS);
         NWP_128: period_ticks = 16'(128 * TICKS_PER_MS);
         NWP_256: period_ticks = 16'(256 * TICKS_PER_MS);
         NWP_1024: period_ticks = 16'(1024 * TICKS_PER_MS);
         NWP_4096: period_ticks = 16'(4096 * TICKS_PER_MS);
         default: period_ticks = 16'h0000;
      endcase
   endfunction

   // Watchdog behaviour that follows from selected code, chip mode and RXD
   function automatic wrs_wd_eff_type wd_eff_of(input logic [2:0] watchdog_mode_sel, input logic sw_dev_mode_ctrl,
                                                input wrs_op_mode_type om, input logic rxd_low);
      wd_eff_of = WD_OFF;
      case (watchdog_mode_sel)
         WMC_WINDOW:
         begin
            if (om == OM_NORMAL)
               wd_eff_of = WD_WINDOW;
            else if (om == OM_STANDBY || om == OM_SLEEP)
               wd_eff_of = WD_TIMEOUT;
         end
         WMC_TIMEOUT:
         begin
            if (om == OM_NORMAL || om == OM_STANDBY || om == OM_SLEEP)
               wd_eff_of = WD_TIMEOUT;
         end
         WMC_AUTO:
         begin
            if (!sw_dev_mode_ctrl && (om == OM_NORMAL || (om == OM_STANDBY && rxd_low)))
               wd_eff_of = WD_TIMEOUT;
         end
         default: wd_eff_of = WD_OFF;
      endcase
   endfunction

   assign period = period_ticks(st_r.period_sel);
   assign half = {1'b0, period[15:1]};
   assign idx = paddr[8:2];
   assign addr_ok = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0);
   assign access = psel && penable;
   assign wr_commit = access && st_r.pready && pwrite;

   // Cold starts take the selected length, warm starts the shortest
   always_comb
   begin
      rst_len = RST_T_11;
      if (st_r.rst_cold)
      begin
         case (st_r.rst_len_sel)
            2'h0: rst_len = RST_T_00;
            2'h1: rst_len = RST_T_01;
            2'h2: rst_len = RST_T_10;
            default: rst_len = RST_T_11;
         endcase
      end
   end

   // Read multiplexer; unmapped words answer with an error and zero data
   always_comb
   begin
      rd_val = 32'h0000_0000;
      mapped = addr_ok;
      case (idx)
         IDX_WD_CTRL: rd_val[7:0] = {st_r.wd_mode_sel, 1'b0, st_r.period_sel};
         IDX_MODE: rd_val[2:0] = st_r.op_mode;
         IDX_MAIN_STAT: rd_val[4:0] = {st_r.overtemp_warn_status, st_r.cause};
         IDX_WD_STAT:
         begin
            if (st_r.wd_eff == WD_OFF)
               rd_val[1:0] = 2'h0;
            else if (st_r.wd_cnt < half)
               rd_val[1:0] = 2'h1;
            else
               rd_val[1:0] = 2'h2;
         end
         IDX_SUP_CTRL: rd_val[3:0] = {st_r.aux_cfg, st_r.thr_sel};
         IDX_SUP_STAT: rd_val[0] = st_r.sup_low;
         IDX_EVT: rd_val[5:0] = st_r.events;
         IDX_EVT_EN: rd_val[1:0] = st_r.evt_en;
         IDX_STARTUP: rd_val[5:3] = {st_r.rst_len_sel, st_r.aux_startup};
         IDX_CFG: rd_val[5:0] = {st_r.thr_startup, 1'b0, st_r.sw_dev_mode_ctrl, 1'b0, st_r.sleep_dis};
         default: mapped = 1'b0;
      endcase
   end

   // Next-state logic of the whole supervisor
   always_comb
   begin
      logic go_rst;
      logic cold;
      logic trig;
      logic ovf;
      wrs_cause_type why;
      logic [5:0] ev_set;
      logic [5:0] ev_clr;
      wrs_wd_eff_type eff;
      go_rst = 1'b0;
      cold = 1'b0;
      trig = 1'b0;
      ovf = 1'b0;
      why = RC_POR;
      ev_set = 6'h00;
      ev_clr = 6'h00;
      eff = WD_OFF;
      st_nxt = st_r;

      // APB handshake: one wait state, then data and error stand with pready
      st_nxt.pready = access && !st_r.pready;
      st_nxt.pslverr = access && !st_r.pready && !mapped;
      st_nxt.prdata = (access && !st_r.pready && !pwrite && mapped) ? rd_val : 32'h0000_0000;

      // Power-up: load startup selections and flag the event once
      if (st_r.por_pend)
      begin
         st_nxt.por_pend = 1'b0;
         ev_set[EV_PO] = 1'b1;
         st_nxt.aux_cfg = st_r.aux_startup ? 2'h3 : 2'h0;
         st_nxt.thr_sel = st_r.thr_startup;
      end

      // Register writes take effect at the edge that completes the access
      if (wr_commit && mapped)
      begin
         case (idx)
            IDX_WD_CTRL:
            begin
               if (period_ticks(pwdata[3:0]) == 16'h0000 ||
                   !(pwdata[7:5] == WMC_AUTO || pwdata[7:5] == WMC_TIMEOUT ||
                     pwdata[7:5] == WMC_WINDOW))
               begin
                  if (st_r.evt_en[1])
                     ev_set[EV_SPIF] = 1'b1;
               end
               else if (st_r.op_mode == OM_NORMAL &&
                        (pwdata[7:5] != st_r.wd_mode_sel || pwdata[3:0] != st_r.period_sel))
               begin
                  go_rst = 1'b1;
                  why = RC_RECONF;
               end
               else
               begin
                  st_nxt.wd_mode_sel = pwdata[7:5];
                  st_nxt.period_sel = pwdata[3:0];
                  trig = 1'b1;
               end
            end
            IDX_MODE:
            begin
               if (st_r.op_mode == OM_NORMAL || st_r.op_mode == OM_STANDBY)
               begin
                  case (pwdata[2:0])
                     MC_NORMAL: st_nxt.op_mode = OM_NORMAL;
                     MC_STANDBY: st_nxt.op_mode = OM_STANDBY;
                     MC_SLEEP:
                     begin
                        if (st_r.sleep_dis || st_r.events[EV_WAKE])
                        begin
                           go_rst = 1'b1;
                           why = RC_ILL_SLEEP;
                        end
                        else
                           st_nxt.op_mode = OM_SLEEP;
                     end
                     default: st_nxt.op_mode = st_r.op_mode;
                  endcase
               end
            end
            IDX_SUP_CTRL: {st_nxt.aux_cfg, st_nxt.thr_sel} = pwdata[3:0];
            IDX_EVT: ev_clr = pwdata[5:0];
            IDX_EVT_EN: st_nxt.evt_en = pwdata[1:0];
            IDX_STARTUP: {st_nxt.rst_len_sel, st_nxt.aux_startup} = pwdata[5:3];
            IDX_CFG:
            begin
               st_nxt.thr_startup = pwdata[5:4];
               st_nxt.sw_dev_mode_ctrl = pwdata[2];
               st_nxt.sleep_dis = pwdata[0];
            end
            default: st_nxt.prdata = st_nxt.prdata;
         endcase
      end

      // Watchdog timer; a change of behaviour restarts it from zero
      eff = wd_eff_of(st_r.wd_mode_sel, st_r.sw_dev_mode_ctrl, st_r.op_mode, st_r.rxd_force);
      st_nxt.wd_eff = eff;
      if (eff == WD_OFF || eff != st_r.wd_eff)
         st_nxt.wd_cnt = 16'h0000;
      else if (trig)
      begin
         if (eff == WD_WINDOW && st_r.wd_cnt < half)
         begin
            go_rst = 1'b1;
            why = RC_WIN_EARLY;
         end
         st_nxt.wd_cnt = 16'h0000;
      end
      else if (tick)
      begin
         if (st_r.wd_cnt + 16'h0001 >= period)
         begin
            ovf = 1'b1;
            st_nxt.wd_cnt = 16'h0000;
         end
         else
            st_nxt.wd_cnt = st_r.wd_cnt + 16'h0001;
      end
      if (ovf && eff == WD_WINDOW)
      begin
         go_rst = 1'b1;
         why = RC_WIN_OVF;
      end
      else if (ovf && st_r.op_mode == OM_SLEEP)
      begin
         ev_set[EV_WAKE] = 1'b1;
         ev_set[EV_WDF] = 1'b1;
         if (st_r.events[EV_WDF])
         begin
            // Supply back on so the host can clear the flag and retrigger
            st_nxt.rxd_force = 1'b1;
            st_nxt.v1_en = 1'b1;
            st_nxt.op_mode = OM_STANDBY;
         end
      end
      else if (ovf && st_r.events[EV_WDF])
      begin
         go_rst = 1'b1;
         why = RC_TO_OVF;
      end
      else if (ovf)
         ev_set[EV_WDF] = 1'b1;

      // Wake-ups: autonomous mode stays out of Reset, others reset from Sleep
      if (wake_i && !ovf)
      begin
         if (st_r.wd_mode_sel == WMC_AUTO && eff == WD_OFF &&
             (st_r.op_mode == OM_SLEEP || st_r.op_mode == OM_STANDBY))
         begin
            ev_set[EV_WAKE] = 1'b1;
            st_nxt.rxd_force = 1'b1;
            st_nxt.v1_en = 1'b1;
            st_nxt.op_mode = OM_STANDBY;
         end
         else if (st_r.op_mode == OM_SLEEP)
         begin
            ev_set[EV_WAKE] = 1'b1;
            go_rst = 1'b1;
            cold = 1'b1;
            why = RC_SLEEP_WAKE;
         end
      end

      // Supply monitor; the selected threshold index follows the 90..60 order
      st_nxt.sup_low = supply_uv_i[0];
      if (supply_uv_i[0] && !st_r.sup_low && st_r.evt_en[0])
         ev_set[EV_V1U] = 1'b1;
      if (supply_uv_i[st_r.thr_sel] && st_r.op_mode != OM_SLEEP &&
          st_r.op_mode != OM_OVERTEMP)
      begin
         go_rst = 1'b1;
         cold = 1'b1;
         why = RC_UV;
      end

      // External pull-down seen while the pin is not driven here
      if (!reset_out_n_i && !st_r.pin_oe && st_r.op_mode != OM_SLEEP &&
          st_r.op_mode != OM_OVERTEMP)
      begin
         go_rst = 1'b1;
         why = RC_EXT;
      end

      // Temperature is not watched in Sleep, so the warning is held there
      if (st_r.op_mode != OM_SLEEP)
      begin
         st_nxt.overtemp_warn_status = overtemp_warn_i;
         if (overtemp_warn_i && !st_r.overtemp_warn_status)
            ev_set[EV_OTW] = 1'b1;
      end

      // Reset mode: count the pulse, release, wait for the pin to rise
      if (st_r.op_mode == OM_RESET)
      begin
         if (st_r.pin_oe)
         begin
            if (tick)
               st_nxt.rst_ticks = st_r.rst_ticks + 8'h01;
            if (st_r.rst_ticks > rst_len)
               st_nxt.pin_oe = 1'b0;
         end
         else if (reset_out_n_i)
            st_nxt.op_mode = OM_STANDBY;
         // A reset while already here only restarts the pulse
         if (go_rst)
         begin
            go_rst = 1'b0;
            st_nxt.rst_ticks = 8'h00;
            st_nxt.pin_oe = 1'b1;
            st_nxt.rst_cold = st_r.rst_cold || cold;
         end
      end

      // Overtemp has priority: pin low, main supply and transceiver off
      if (st_r.op_mode == OM_OVERTEMP)
      begin
         go_rst = 1'b0;
         st_nxt.op_mode = OM_OVERTEMP;
         if (!overtemp_i)
         begin
            go_rst = 1'b1;
            cold = 1'b1;
            why = RC_OTEMP;
         end
      end
      else if (overtemp_i && st_r.op_mode != OM_SLEEP)
      begin
         go_rst = 1'b0;
         st_nxt.op_mode = OM_OVERTEMP;
         st_nxt.pin_oe = 1'b1;
      end

      // System reset entry: restore watchdog defaults
      if (go_rst)
      begin
         st_nxt.op_mode = OM_RESET;
         st_nxt.pin_oe = 1'b1;
         st_nxt.rst_ticks = 8'h00;
         st_nxt.rst_cold = cold;
         st_nxt.cause = why;
         st_nxt.wd_mode_sel = st_r.sw_dev_mode_ctrl ? WMC_AUTO : WMC_TIMEOUT;
         st_nxt.period_sel = NWP_128;
      end

      // Outputs that follow the resulting mode
      st_nxt.xcvr_en = (st_nxt.op_mode == OM_NORMAL);
      if (st_nxt.op_mode == OM_OVERTEMP || st_nxt.op_mode == OM_SLEEP)
         st_nxt.v1_en = 1'b0;
      else if (st_nxt.op_mode != st_r.op_mode || st_r.op_mode != OM_SLEEP)
         st_nxt.v1_en = 1'b1;

      // Events: set beats a clear in the same cycle; RXD force ends with wake
      st_nxt.events = (st_r.events & ~ev_clr) | ev_set;
      if (!st_nxt.events[EV_WAKE])
         st_nxt.rxd_force = 1'b0;
   end

   // Power-up leaves Off mode into a cold Reset with the pin driven low
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         st_r <= '0;
         st_r.op_mode <= OM_RESET;
         st_r.cause <= RC_POR;
         st_r.wd_mode_sel <= WMC_TIMEOUT;
         st_r.period_sel <= NWP_128;
         st_r.rst_cold <= 1'b1;
         st_r.pin_oe <= 1'b1;
         st_r.v1_en <= 1'b1;
         st_r.por_pend <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   // Every output but reset_out_n_o comes straight from the state register; that pin is always driven low
   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign reset_out_n_o = st_r.por_pend & ~st_r.por_pend;
   assign reset_out_n_oe_o = st_r.pin_oe;
   assign rxd_force_low_o = st_r.rxd_force;
   assign main_supply_en_o = st_r.v1_en;
   assign xcvr_en_o = st_r.xcvr_en;
   assign op_mode_o = st_r.op_mode;
endmodule
`default_nettype wire

// ---- hdl/wrs_tick_gen.sv ----
// Free-running prescaler that gives one tick pulse every TICK_CYC core clocks.
// Assumes one clock domain; the tick feeds the watchdog and reset pulse counters.
`default_nettype none
module wrs_tick_gen
   import wrs_pkg::*;
#(
   parameter int TICK_CYC_P = TICK_CYC
)
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   output logic tick_o
);
   wrs_tick_state_type st_r;
   wrs_tick_state_type st_nxt;

   // Refuse a divider that the 16-bit counter cannot hold
   if (TICK_CYC_P < 2 || TICK_CYC_P > 65535)
   begin : g_bad_div
      $error("wrs_tick_gen: TICK_CYC_P out of range");
   end

   // Count down to the tick so the divider stays one comparator wide
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (st_r.cnt == 16'h0000)
      begin
         st_nxt.cnt = 16'(TICK_CYC_P - 1);
         st_nxt.tick = 1'b1;
      end
      else
         st_nxt.cnt = st_r.cnt - 16'h0001;
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign tick_o = st_r.tick;
endmodule
`default_nettype wire

// ---- shared/wrs_pkg.sv ----
// Constants, register map, codes and state layouts of the watchdog and reset supervisor.
// Assumes a 40 MHz core clock and an APB slave with one 32-bit word per register.
`default_nettype none
package wrs_pkg;
   // Timing base: a 100 us tick derived from the core clock
   localparam int CLK_KHZ = 40_000;
   localparam int TICK_US = 100;
   localparam int TICK_CYC = TICK_US * CLK_KHZ / 1000;
   // Least reset pulse widths in us, turned into ticks rounded up
   localparam int RST_US_00 = 20_000;
   localparam int RST_US_01 = 10_000;
   localparam int RST_US_10 = 3_600;
   localparam int RST_US_11 = 1_000;
   localparam logic [7:0] RST_T_00 = 8'((RST_US_00 + TICK_US - 1) / TICK_US);
   localparam logic [7:0] RST_T_01 = 8'((RST_US_01 + TICK_US - 1) / TICK_US);
   localparam logic [7:0] RST_T_10 = 8'((RST_US_10 + TICK_US - 1) / TICK_US);
   localparam logic [7:0] RST_T_11 = 8'((RST_US_11 + TICK_US - 1) / TICK_US);
   localparam int TICKS_PER_MS = 1000 / TICK_US;
   // Watchdog mode and period codes
   localparam logic [2:0] WMC_AUTO = 3'h1;
   localparam logic [2:0] WMC_TIMEOUT = 3'h2;
   localparam logic [2:0] WMC_WINDOW = 3'h4;
   localparam logic [3:0] NWP_8 = 4'h8;
   localparam logic [3:0] NWP_16 = 4'h1;
   localparam logic [3:0] NWP_32 = 4'h2;
   localparam logic [3:0] NWP_64 = 4'hB;
   localparam logic [3:0] NWP_128 = 4'h4;
   localparam logic [3:0] NWP_256 = 4'hD;
   localparam logic [3:0] NWP_1024 = 4'hE;
   localparam logic [3:0] NWP_4096 = 4'h7;
   // Register indices; byte address is four times the index
   localparam logic [6:0] IDX_WD_CTRL = 7'h00;
   localparam logic [6:0] IDX_MODE = 7'h01;
   localparam logic [6:0] IDX_MAIN_STAT = 7'h03;
   localparam logic [6:0] IDX_WD_STAT = 7'h05;
   localparam logic [6:0] IDX_SUP_CTRL = 7'h10;
   localparam logic [6:0] IDX_SUP_STAT = 7'h1B;
   localparam logic [6:0] IDX_EVT = 7'h61;
   localparam logic [6:0] IDX_EVT_EN = 7'h62;
   localparam logic [6:0] IDX_STARTUP = 7'h73;
   localparam logic [6:0] IDX_CFG = 7'h74;
   // Operating mode request codes in the mode register
   localparam logic [2:0] MC_SLEEP = 3'h1;
   localparam logic [2:0] MC_STANDBY = 3'h4;
   localparam logic [2:0] MC_NORMAL = 3'h7;
   // Event register bit positions
   localparam int EV_PO = 0;
   localparam int EV_OTW = 1;
   localparam int EV_V1U = 2;
   localparam int EV_SPIF = 3;
   localparam int EV_WAKE = 4;
   localparam int EV_WDF = 5;
   typedef enum logic [2:0] {
      OM_RESET = 3'h0, OM_STANDBY = 3'h1, OM_NORMAL = 3'h2,
      OM_SLEEP = 3'h3, OM_OVERTEMP = 3'h4
   } wrs_op_mode_type;
   typedef enum logic [1:0] {
      WD_OFF = 2'h0, WD_WINDOW = 2'h1, WD_TIMEOUT = 2'h2
   } wrs_wd_eff_type;
   typedef enum logic [3:0] {
      RC_POR = 4'h0, RC_WIN_EARLY = 4'h1, RC_WIN_OVF = 4'h2, RC_TO_OVF = 4'h3,
      RC_RECONF = 4'h4, RC_EXT = 4'h5, RC_UV = 4'h6, RC_OTEMP = 4'h7,
      RC_SLEEP_WAKE = 4'h8, RC_ILL_SLEEP = 4'h9
   } wrs_cause_type;
   typedef struct packed {
      wrs_op_mode_type op_mode;
      wrs_wd_eff_type wd_eff;
      logic [2:0] wd_mode_sel;
      logic [3:0] period_sel;
      logic [15:0] wd_cnt;
      logic [7:0] rst_ticks;
      logic rst_cold;
      wrs_cause_type cause;
      logic [1:0] rst_len_sel;
      logic aux_startup;
      logic [1:0] aux_cfg;
      logic [1:0] thr_sel;
      logic [1:0] thr_startup;
      logic sw_dev_mode_ctrl;
      logic sleep_dis;
      logic [5:0] events;
      logic [1:0] evt_en;
      logic overtemp_warn_status;
      logic sup_low;
      logic pin_oe;
      logic rxd_force;
      logic v1_en;
      logic xcvr_en;
      logic por_pend;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } wrs_state_type;
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } wrs_tick_state_type;
endpackage
`default_nettype wire

// ---- tb/wrs_host_model.sv ----
// Host end of the reset wire: pull-up and the host's own pull-down.
// Level goes back to the supervisor's sense input.
`default_nettype none
module wrs_host_model
(
   input wire logic oe_i,
   input wire logic pull_i,
   output logic wire_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pull-up wins only when nobody sinks the line
   assign wire_o = !(oe_i || pull_i);
endmodule
`default_nettype wire

// ---- tb/wrs_supervisor_assertions.sv ----
// Checker for the supervisor pins and APB answers.
// Bound into wrs_supervisor; sees its ports only.
`default_nettype none
module wrs_sva
   import wrs_pkg::*;
#(
   parameter int TICK_CYC_P = TICK_CYC
)
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic [3:0] supply_uv_i,
   input wire logic overtemp_i,
   input wire logic reset_out_n_i,
   input wire logic reset_out_n_o,
   input wire logic reset_out_n_oe_o,
   input wire logic main_supply_en_o,
   input wire logic xcvr_en_o,
   input wire logic [2:0] op_mode_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Warm pulse floor, cold pulse ceiling plus overtemp hold
   localparam int LO = 10 * TICK_CYC_P;
   localparam int HI = 252 * TICK_CYC_P;
   logic [31:0] oe_cyc_r;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   // Length of the present reset pulse
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         oe_cyc_r <= 32'h0000_0000;
      else
         oe_cyc_r <= reset_out_n_oe_o ? oe_cyc_r + 32'h0000_0001 : 32'h0000_0000;
   end
   property p_wds; pready && !pwrite && paddr == {3'h0, IDX_WD_STAT, 2'b00} |-> prdata[1:0] != 2'b11; endproperty
   a_wds: assert property (p_wds) else $error("reserved watchdog state");
   property p_rst; $rose(reset_out_n_oe_o) |-> op_mode_o inside {OM_RESET, OM_OVERTEMP}; endproperty
   a_rst: assert property (p_rst) else $error("pulse outside reset mode");
   property p_od; reset_out_n_oe_o |-> reset_out_n_o == 1'b0; endproperty
   a_od: assert property (p_od) else $error("reset pin driven high");
   property p_ot; $rose(overtemp_i) |-> ##[1:3] op_mode_o == OM_OVERTEMP; endproperty
   a_ot: assert property (p_ot) else $error("no overtemp mode");
   property p_otoff; op_mode_o == OM_OVERTEMP |-> reset_out_n_oe_o && !main_supply_en_o && !xcvr_en_o; endproperty
   a_otoff: assert property (p_otoff) else $error("overtemp outputs wrong");
   property p_uv; $rose(supply_uv_i[3]) |-> ##[1:3] reset_out_n_oe_o && op_mode_o == OM_RESET; endproperty
   a_uv: assert property (p_uv) else $error("no undervoltage reset");
   property p_ext; op_mode_o == OM_STANDBY && !reset_out_n_i && !reset_out_n_oe_o |=> reset_out_n_oe_o; endproperty
   a_ext: assert property (p_ext) else $error("external pull-down missed");
   property p_len; $fell(reset_out_n_oe_o) |-> oe_cyc_r inside {[LO:HI]}; endproperty
   a_len: assert property (p_len) else $error("reset pulse length");
   c_pulse: cover property ($fell(reset_out_n_oe_o));
   c_ot: cover property (op_mode_o == OM_OVERTEMP);
   c_norm: cover property (op_mode_o == OM_NORMAL);
endmodule
bind wrs_supervisor wrs_sva #(.TICK_CYC_P(TICK_CYC_P)) sva (.*);
`default_nettype wire

// ---- tb/wrs_supervisor_tb.sv ----
// Bench for the supervisor: APB sequences and pin stimulus.
// Needs wrs_pkg, the checker bind and the host model; 4-cycle tick.
`default_nettype none
module wrs_supervisor_tb
   import wrs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 0, reset_n_i = 0, psel = 0, penable = 0, pwrite = 0, pull = 0;
   logic overtemp_i = 0, overtemp_warn_i = 0, wake_i = 0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] supply_uv_i = 4'h0;
   logic [2:0] op_mode_o;
   logic pready, pslverr, reset_out_n_i, reset_out_n_o, reset_out_n_oe_o;
   logic rxd_force_low_o, main_supply_en_o, xcvr_en_o;
   int mismatches = 0, tests_run = 0;
   wrs_supervisor #(.TICK_CYC_P(4)) dut (.*);
   wrs_host_model host (.oe_i(reset_out_n_oe_o), .pull_i(pull), .wire_o(reset_out_n_i));
   // 40 MHz core clock
   always #12.5 core_clk_i = ~core_clk_i;
   task automatic results();
      $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer held until pready, then one idle cycle
   task automatic xf(input logic w, input logic [6:0] i, input logic [31:0] d, output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {3'h0, i, 2'b00};
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      @(posedge core_clk_i);
      while (pready !== 1'b1) @(posedge core_clk_i);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic wr(input logic [6:0] i, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      xf(1'b1, i, d, q, e);
   endtask
   task automatic chk(input logic [6:0] i, input logic [31:0] m, input logic [31:0] x);
      logic [31:0] q;
      logic e;
      xf(1'b0, i, 32'h0, q, e);
      cmp(q & m, x);
   endtask
   task automatic wm(input wrs_op_mode_type m);
      repeat (20000)
      begin
         @(posedge core_clk_i);
         if (op_mode_o === m)
            break;
      end
      cmp({29'h0, op_mode_o}, {29'h0, m});
   endtask
   task automatic tk(input int n);
      repeat (n * 4) @(posedge core_clk_i);
   endtask
   // Reset pulse, pins released, Standby again, cause read back
   task automatic rs(input wrs_cause_type c);
      wm(OM_RESET);
      pull <= 1'b0;
      supply_uv_i <= 4'h0;
      wm(OM_STANDBY);
      chk(IDX_MAIN_STAT, 32'hF, 32'(c));
   endtask
   // Hang guard, well beyond the sequence length
   initial
   begin
      #1_500_000;
      mismatches++;
      results();
   end
   initial
   begin
      logic [31:0] q;
      logic e;
      repeat (6) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      wm(OM_STANDBY);
      chk(IDX_EVT, 32'h1, 32'h1); // Power-on event
      chk(IDX_SUP_CTRL, 32'hC, 32'h0);
      chk(IDX_WD_CTRL, 32'hEF, 32'h44); // Timeout, 128 ms
      xf(1'b0, 7'h7C, 32'h0, q, e);
      cmp({31'h0, e}, 32'h1); // Unmapped read refused
      wr(IDX_EVT_EN, 32'h3);
      wr(IDX_WD_CTRL, 32'h64); // Bad mode code
      wr(IDX_WD_CTRL, 32'h49); // Bad period code
      chk(IDX_WD_CTRL, 32'hEF, 32'h44);
      chk(IDX_EVT, 32'h8, 32'h8);
      wr(IDX_WD_CTRL, 32'h48); // 8 ms in Standby
      tk(100);
      chk(IDX_EVT, 32'h20, 32'h20); // Failure flag
      rs(RC_TO_OVF);
      wr(IDX_EVT, 32'h3F);
      wr(IDX_WD_CTRL, 32'h88); // Window code, still Standby
      wr(IDX_MODE, 32'h7);
      chk(IDX_WD_STAT, 32'h3, 32'h1);
      wr(IDX_WD_CTRL, 32'h88); // Early trigger
      rs(RC_WIN_EARLY);
      wr(IDX_WD_CTRL, 32'h88);
      wr(IDX_MODE, 32'h7);
      tk(60);
      chk(IDX_WD_STAT, 32'h3, 32'h2);
      wr(IDX_WD_CTRL, 32'h88); // Late trigger
      chk(IDX_WD_STAT, 32'h3, 32'h1); // Restarted
      rs(RC_WIN_OVF);
      wr(IDX_MODE, 32'h7);
      wr(IDX_WD_CTRL, 32'h88); // Mode change in Normal
      rs(RC_RECONF);
      pull <= 1'b1;
      rs(RC_EXT);
      overtemp_warn_i <= 1'b1;
      tk(1);
      chk(IDX_MAIN_STAT, 32'h10, 32'h10);
      chk(IDX_EVT, 32'h2, 32'h2);
      wr(IDX_SUP_CTRL, 32'h3); // Threshold at 60 percent
      supply_uv_i <= 4'h1;
      tk(1);
      chk(IDX_SUP_STAT, 32'h1, 32'h1);
      chk(IDX_EVT, 32'h4, 32'h4);
      supply_uv_i <= 4'hF;
      rs(RC_UV);
      overtemp_i <= 1'b1;
      tk(1);
      cmp({29'h0, op_mode_o}, {29'h0, OM_OVERTEMP});
      overtemp_i <= 1'b0;
      rs(RC_OTEMP);
      wr(IDX_CFG, 32'h4);
      pull <= 1'b1;
      rs(RC_EXT);
      chk(IDX_WD_CTRL, 32'hE0, 32'h20); // Autonomous
      wr(IDX_MODE, 32'h7);
      chk(IDX_WD_STAT, 32'h3, 32'h0); // Off
      wr(IDX_CFG, 32'h0);
      chk(IDX_WD_STAT, 32'h3, 32'h1); // Timeout in Normal
      // Sleep with Timeout: second overflow wakes without a reset
      wr(IDX_MODE, 32'h4);
      wr(IDX_WD_CTRL, 32'h48); // Timeout, 8 ms
      wr(IDX_EVT, 32'h3F);
      wr(IDX_MODE, 32'h1);
      cmp({29'h0, op_mode_o}, {29'h0, OM_SLEEP});
      wm(OM_STANDBY);
      cmp({30'h0, rxd_force_low_o, main_supply_en_o}, 32'h3);
      wr(IDX_EVT, 32'h30); // Host clears failure flag
      wr(IDX_WD_CTRL, 32'h48); // Host retriggers
      tk(100);
      cmp({29'h0, op_mode_o}, {29'h0, OM_STANDBY}); // Overflow without reset
      // Autonomous wake in Standby starts the timer
      wr(IDX_WD_CTRL, 32'h28);
      chk(IDX_WD_STAT, 32'h3, 32'h0);
      wake_i <= 1'b1;
      tk(1);
      wake_i <= 1'b0;
      cmp({31'h0, rxd_force_low_o}, 32'h1);
      chk(IDX_WD_STAT, 32'h3, 32'h1);
      results();
   end
endmodule
`default_nettype wire
